/* rtl/srx_align_ctrl.sv */
// Receive link control, lane crossbar, boundary offset and skew measurement
//
// Operation
// RQ1: Software enables the link only after parameters, PLL lock and PHY calibration.
// RQ2: Read-only 5-bit skew from receive boundary to last lane boundary.
// RQ3: Receive boundary delayed by 5-bit offset; subclass picks PCLK or frame units.
// RQ4: Buffered lane data released at programmable PCLK point; resets to 0x6.
// RQ5: Software never programs the release point above 10.
// RQ6: Each logical lane takes the physical input named by its 3-bit selector.
// RQ7: Selector x routes input x; selectors reset to identity mapping.
// RQ8: One PCLK cycle carries four octets of lane data.
// RQ9: Link enable clear keeps alignment idle and discards lane data.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "srx_map.svh"

module srx_align_ctrl
  import srx_pkg::*;
#(
  parameter int LANES = `SRX_LANES,
  parameter int DEPTH = `SRX_BUF_DEPTH
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic lmfc_tick,
  input wire logic frame_tick,
  input wire srx_lane_t [LANES-1:0] serial_input_n,
  output srx_lane_t [LANES-1:0] lane_out,
  output logic lmfc_rx_out,
  output logic link_active
);

  logic link_en_r;
  logic [`SRX_CLASS_W-1:0] local_sync_class_r;
  srx_cnt_t boundary_offset_setting_r;
  srx_cnt_t buffer_release_point_r;
  srx_cnt_t measured_arrival_skew_r;
  srx_src_t lane_src_r [LANES];

  logic [9:0] idx;
  logic aligned;
  logic access;
  logic wr_fire;
  logic mapped;
  logic [31:0] rd_val;
  logic release_pulse;

  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign access = psel && penable;
  assign wr_fire = access && pready && pwrite && mapped;

  always_comb
  begin
    mapped = aligned;
    rd_val = '0;
    if (idx == `SRX_IDX_GEN_CTRL)
      rd_val[`SRX_LINK_EN_BIT] = link_en_r;
    else if (idx == `SRX_IDX_SUBCLASS)
      rd_val[`SRX_CLASS_W-1:0] = local_sync_class_r;
    else if (idx == `SRX_IDX_SKEW)
      rd_val[`SRX_CNT_W-1:0] = measured_arrival_skew_r; // RQ2
    else if (idx == `SRX_IDX_OFFSET)
      rd_val[`SRX_CNT_W-1:0] = boundary_offset_setting_r;
    else if (idx == `SRX_IDX_RELEASE)
      rd_val[`SRX_CNT_W-1:0] = buffer_release_point_r;
    else if (idx == `SRX_IDX_MAP_LOW)
    begin
      rd_val[`SRX_SRC_EVEN_LSB +: `SRX_SRC_W] = lane_src_r[0];
      rd_val[`SRX_SRC_ODD_LSB +: `SRX_SRC_W] = lane_src_r[1];
    end
    else if (idx == `SRX_IDX_MAP_HIGH)
    begin
      rd_val[`SRX_SRC_EVEN_LSB +: `SRX_SRC_W] = lane_src_r[2];
      rd_val[`SRX_SRC_ODD_LSB +: `SRX_SRC_W] = lane_src_r[3];
    end
    else
      mapped = 1'b0;
    if (!aligned)
      rd_val = '0;
  end

  // One wait state: answer in the second access cycle, data from flops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (access && !pready)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0 : rd_val;
      pslverr <= !mapped;
    end
    else
    begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      link_en_r <= 1'b0;
      local_sync_class_r <= `SRX_RST_SUBCLASS;
      boundary_offset_setting_r <= `SRX_RST_OFFSET;
      buffer_release_point_r <= `SRX_RST_RELEASE; // RQ4
    end
    else if (wr_fire)
    begin
      if (idx == `SRX_IDX_GEN_CTRL)
        link_en_r <= pwdata[`SRX_LINK_EN_BIT]; // RQ1
      else if (idx == `SRX_IDX_SUBCLASS)
        local_sync_class_r <= pwdata[`SRX_CLASS_W-1:0];
      else if (idx == `SRX_IDX_OFFSET)
        boundary_offset_setting_r <= pwdata[`SRX_CNT_W-1:0];
      else if (idx == `SRX_IDX_RELEASE)
        buffer_release_point_r <= pwdata[`SRX_CNT_W-1:0]; // RQ5
    end
  end

  // Selector registers; identity map after reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lane_src_r[0] <= `SRX_RST_SRC0; // RQ7
      lane_src_r[1] <= `SRX_RST_SRC1; // RQ7
      lane_src_r[2] <= `SRX_RST_SRC2; // RQ7
      lane_src_r[3] <= `SRX_RST_SRC3; // RQ7
    end
    else if (wr_fire && idx == `SRX_IDX_MAP_LOW)
    begin
      lane_src_r[0] <= pwdata[`SRX_SRC_EVEN_LSB +: `SRX_SRC_W]; // RQ6
      lane_src_r[1] <= pwdata[`SRX_SRC_ODD_LSB +: `SRX_SRC_W]; // RQ6
    end
    else if (wr_fire && idx == `SRX_IDX_MAP_HIGH)
    begin
      lane_src_r[2] <= pwdata[`SRX_SRC_EVEN_LSB +: `SRX_SRC_W]; // RQ6
      lane_src_r[3] <= pwdata[`SRX_SRC_ODD_LSB +: `SRX_SRC_W]; // RQ6
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      link_active <= 1'b0;
    else
      link_active <= link_en_r;
  end

  // Crossbar: one flop stage; selectors naming no input give an idle lane
  srx_lane_t routed_r [LANES];
  srx_lane_t routed_w [LANES];

  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_xbar
      always_comb
      begin
        routed_w[g] = '0;
        if (32'(lane_src_r[g]) < LANES)
          routed_w[g] = serial_input_n[lane_src_r[g]]; // RQ6 RQ7 RQ8
      end

      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
          routed_r[g] <= '0;
        else if (!link_en_r)
          routed_r[g] <= '0; // RQ9
        else
          routed_r[g] <= routed_w[g];
      end

      srx_lane_buf #(
        .DEPTH(DEPTH)
      ) u_buf (
        .clk(clk),
        .reset_n(reset_n),
        .run(link_en_r), // RQ9
        .lane_in(routed_r[g]),
        .release_pulse(release_pulse),
        .lane_out(lane_out[g])
      );
    end
  endgenerate

  // Receive boundary: offset counted in PCLK (class 0) or frame ticks (class 1)
  srx_ofs_state_t ofs_state_r;
  srx_cnt_t ofs_cnt_r;
  logic unit_tick;
  logic lmfc_rx_now;

  assign unit_tick = (local_sync_class_r == `SRX_CLASS_ONE) ? frame_tick
                                                            : 1'b1; // RQ3
  assign lmfc_rx_now = link_en_r &&
    ((lmfc_tick && boundary_offset_setting_r == '0) ||
     (ofs_state_r == SRX_OFS_COUNT && unit_tick &&
      ofs_cnt_r == `SRX_CNT_ONE));

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ofs_state_r <= SRX_OFS_IDLE;
      ofs_cnt_r <= '0;
    end
    else if (!link_en_r)
      ofs_state_r <= SRX_OFS_IDLE; // RQ9
    else
      case (ofs_state_r)
        SRX_OFS_IDLE:
          if (lmfc_tick && boundary_offset_setting_r != '0)
          begin
            ofs_state_r <= SRX_OFS_COUNT;
            ofs_cnt_r <= boundary_offset_setting_r; // RQ3
          end
        SRX_OFS_COUNT:
          if (unit_tick)
          begin
            ofs_cnt_r <= ofs_cnt_r - 1'b1;
            if (ofs_cnt_r == `SRX_CNT_ONE)
              ofs_state_r <= SRX_OFS_IDLE;
          end
        default:
          ofs_state_r <= SRX_OFS_IDLE;
      endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      lmfc_rx_out <= 1'b0;
    else
      lmfc_rx_out <= lmfc_rx_now;
  end

  // Release point: PCLK cycles after the receive boundary, first time only
  logic rel_run_r;
  logic rel_done_r;
  srx_cnt_t rel_cnt_r;

  assign release_pulse = link_en_r && !rel_done_r &&
    ((lmfc_rx_now && !rel_run_r && buffer_release_point_r == '0) ||
     (rel_run_r && rel_cnt_r == buffer_release_point_r)); // RQ4

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rel_run_r <= 1'b0;
      rel_done_r <= 1'b0;
      rel_cnt_r <= '0;
    end
    else if (!link_en_r)
    begin
      rel_run_r <= 1'b0;
      rel_done_r <= 1'b0;
      rel_cnt_r <= '0;
    end
    else if (release_pulse)
    begin
      rel_run_r <= 1'b0;
      rel_done_r <= 1'b1;
    end
    else if (rel_run_r)
      rel_cnt_r <= rel_cnt_r + 1'b1;
    else if (lmfc_rx_now && !rel_done_r)
    begin
      rel_run_r <= 1'b1;
      rel_cnt_r <= `SRX_CNT_ONE;
    end
  end

  // Skew: cycles from the receive boundary until every lane has shown its own
  logic [LANES-1:0] seen_r;
  logic [LANES-1:0] marks;
  logic meas_r;
  srx_cnt_t meas_cnt_r;

  always_comb
  begin
    marks = '0;
    for (int i = 0; i < LANES; i++)
      marks[i] = routed_r[i].valid && routed_r[i].boundary;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      seen_r <= '0;
      meas_r <= 1'b0;
      meas_cnt_r <= '0;
      measured_arrival_skew_r <= `SRX_RST_SKEW;
    end
    else if (!link_en_r)
    begin
      seen_r <= '0;
      meas_r <= 1'b0;
      meas_cnt_r <= '0;
    end
    else if (lmfc_rx_now)
    begin
      seen_r <= marks;
      meas_r <= 1'b1;
      meas_cnt_r <= '0;
      if (&marks)
      begin
        meas_r <= 1'b0;
        measured_arrival_skew_r <= '0; // RQ2
      end
    end
    else if (meas_r)
    begin
      seen_r <= seen_r | marks;
      if (meas_cnt_r != `SRX_SKEW_MAX)
        meas_cnt_r <= meas_cnt_r + 1'b1;
      if (&(seen_r | marks))
      begin
        meas_r <= 1'b0;
        measured_arrival_skew_r <= (meas_cnt_r == `SRX_SKEW_MAX) ?
          `SRX_SKEW_MAX : meas_cnt_r + 1'b1; // RQ2
      end
    end
  end

endmodule // srx_align_ctrl

/* common/srx_map.svh */
// Register indices, field positions, reset values and counts of the receive link block
`ifndef SRX_MAP_SVH
`define SRX_MAP_SVH

`define SRX_IDX_GEN_CTRL 10'h300
`define SRX_IDX_SUBCLASS 10'h301
`define SRX_IDX_SKEW 10'h302
`define SRX_IDX_OFFSET 10'h304
`define SRX_IDX_RELEASE 10'h306
`define SRX_IDX_MAP_LOW 10'h308
`define SRX_IDX_MAP_HIGH 10'h309

`define SRX_LINK_EN_BIT 0
`define SRX_CLASS_W 3
`define SRX_CNT_W 5
`define SRX_SRC_W 3
`define SRX_SRC_EVEN_LSB 0
`define SRX_SRC_ODD_LSB 3

`define SRX_RST_SUBCLASS 3'h1
`define SRX_RST_OFFSET 5'h00
`define SRX_RST_RELEASE 5'h06
`define SRX_RST_SKEW 5'h00
`define SRX_RST_SRC0 3'h0
`define SRX_RST_SRC1 3'h1
`define SRX_RST_SRC2 3'h2
`define SRX_RST_SRC3 3'h3
`define SRX_CNT_ONE 5'h01
`define SRX_CLASS_ZERO 3'h0
`define SRX_CLASS_ONE 3'h1
`define SRX_SKEW_MAX 5'h1f

`define SRX_LANES 4
`define SRX_LANE_OCTETS 4
`define SRX_OCTET_W 8
`define SRX_BUF_DEPTH 32

`endif

/* common/srx_pkg.sv */
// Types shared by the receive link alignment block
`include "srx_map.svh"

package srx_pkg;

  typedef logic [`SRX_LANE_OCTETS*`SRX_OCTET_W-1:0] srx_word_t;

  // One processing-clock beat of one lane: four octets
  typedef struct packed {
    logic valid;
    logic boundary;
    srx_word_t data;
  } srx_lane_t;

  typedef logic [`SRX_SRC_W-1:0] srx_src_t;
  typedef logic [`SRX_CNT_W-1:0] srx_cnt_t;

  typedef enum logic [1:0] {
    SRX_OFS_IDLE,
    SRX_OFS_COUNT
  } srx_ofs_state_t;

endpackage

/* rtl/srx_lane_buf.sv */
// Alignment buffer of one logical lane with deterministic read release
`timescale 1ns/1ps
`include "srx_map.svh"

module srx_lane_buf
  import srx_pkg::*;
#(
  parameter int DEPTH = `SRX_BUF_DEPTH
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic run,
  input wire srx_lane_t lane_in,
  input wire logic release_pulse,
  output srx_lane_t lane_out
);

  localparam int AW = $clog2(DEPTH);

  srx_lane_t mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic wr_on_r;
  logic rd_on_r;

  // Writing starts at the lane's first multiframe boundary
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_on_r <= 1'b0;
      wr_ptr_r <= '0;
    end
    else if (!run)
    begin
      wr_on_r <= 1'b0;
      wr_ptr_r <= '0;
    end
    else if (lane_in.valid && (wr_on_r || lane_in.boundary))
    begin
      wr_on_r <= 1'b1;
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (run && lane_in.valid && (wr_on_r || lane_in.boundary))
      mem[wr_ptr_r] <= lane_in;
  end

  // Reading waits for the common release point so all lanes leave together
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_on_r <= 1'b0;
      rd_ptr_r <= '0;
      lane_out <= '0;
    end
    else if (!run)
    begin
      rd_on_r <= 1'b0;
      rd_ptr_r <= '0;
      lane_out <= '0;
    end
    else if (rd_on_r || (release_pulse && wr_on_r))
    begin
      rd_on_r <= 1'b1;
      rd_ptr_r <= rd_ptr_r + 1'b1;
      lane_out <= mem[rd_ptr_r];
    end
    else
      lane_out <= '0;
  end

endmodule // srx_lane_buf

/* tb/srx_checker.sv */
// Port checks of the receive link alignment block
`timescale 1ns/1ps

module srx_checker
  import srx_pkg::*;
#(
  parameter int LANES = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire srx_lane_t [LANES-1:0] lane_out,
  input wire logic lmfc_rx_out,
  input wire logic link_active
);
  logic v0;
  logic b0;
  assign v0 = lane_out[0].valid;
  assign b0 = lane_out[0].boundary;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Only a completed write may move the enable, seen two edges later
  property p_en;
    $changed(link_active) |-> $past(pready && pwrite, 2);
  endproperty

  a_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held high");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_data_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_en_follows: assert property (p_en)
    else $error("link active moved without a write");
  a_lane_idle: assert property (!link_active |-> lane_out == '0)
    else $error("lane data while link off");
  a_first_mark: assert property ($rose(v0) |-> b0)
    else $error("first released beat not a boundary");
  a_steady: assert property (v0 && link_active |=> v0 || !link_active)
    else $error("released lane stalled");

  c_error: cover property (pslverr);
  c_release: cover property ($rose(v0));
  c_rx_mark: cover property (lmfc_rx_out);
endmodule // srx_checker

bind srx_align_ctrl srx_checker #(.LANES(LANES)) u_chk (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .lane_out(lane_out), .lmfc_rx_out(lmfc_rx_out),
  .link_active(link_active));

/* tb/srx_tx_model.sv */
// Transmitter stream model feeding the four serial inputs
`timescale 1ns/1ps

module srx_tx_model
  import srx_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  output srx_lane_t [3:0] serial_input_n,
  output logic lmfc_tick,
  output logic frame_tick,
  output logic [3:0] phase
);
  logic [15:0] beat_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      beat_r <= 16'h0000;
    else
      beat_r <= beat_r + 16'h0001;
  end

  // Multiframe of 16 beats; frame ticks on odd beats, never with the mark
  assign phase = beat_r[3:0];
  assign lmfc_tick = reset_n && phase == 4'h0;
  assign frame_tick = phase[0];

  // Each input has its own fixed skew of up to 3 beats
  always_comb
  begin
    for (int p = 0; p < 4; p++)
    begin
      serial_input_n[p].valid = reset_n;
      serial_input_n[p].boundary = phase == 4'((p * 3 + 2) % 4);
      serial_input_n[p].data = {8'(p), 8'h00, beat_r};
    end
  end
endmodule // srx_tx_model

/* tb/tb.sv */
// Self-checking bench of the receive link alignment block
`timescale 1ns/1ps
`include "srx_map.svh"

module tb;
  import srx_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, tick, ftick, rx_out, active;
  logic [3:0] phase;
  srx_lane_t [3:0] sin, lout;
  logic [31:0] seed = 32'h00014e4c;
  int bad_count = 0;
  int compares = 0;
  int src [4];
  int rx, v, e, rot;
  logic [9:0] ri [7] = '{10'h300, 10'h301, 10'h302, 10'h304, 10'h306,
    10'h308, 10'h309};
  logic [31:0] rv [7] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h6, 32'h8, 32'h1a};
  int sc [4] = '{0, 0, 1, 1};
  int ofs [4] = '{0, 8, 5, 0};
  int rel [4] = '{6, 10, 0, 5};

  always #12.5 clk = ~clk;

  srx_align_ctrl u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .lmfc_tick(tick),
    .frame_tick(ftick), .serial_input_n(sin), .lane_out(lout),
    .lmfc_rx_out(rx_out), .link_active(active));
  srx_tx_model u_tx (.clk(clk), .reset_n(reset_n), .serial_input_n(sin),
    .lmfc_tick(tick), .frame_tick(ftick), .phase(phase));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Entered after an edge; one idle cycle separates transfers
  task automatic apb(logic w, logic [9:0] idx, logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n == 20)
    begin
      bad_count++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_tick();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (tick !== 1'b1 && n < 40);
    if (n == 40)
    begin
      bad_count++;
      conclude();
    end
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    foreach (ri[i])
    begin
      apb(1'b0, ri[i], 32'h0);
      chk("reset value", rd, rv[i]);
    end
    apb(1'b1, `SRX_IDX_SKEW, 32'h1f);
    apb(1'b0, `SRX_IDX_SKEW, 32'h0);
    chk("skew read only", rd, 32'h0);
    apb(1'b1, `SRX_IDX_OFFSET, 32'hff);
    apb(1'b0, `SRX_IDX_OFFSET, 32'h0);
    chk("offset width", rd, 32'h1f);
    apb(1'b0, 10'h303, 32'h0);
    chk("unmapped error", err, 32'h1);
    for (int c = 0; c < 4; c++)
    begin
      rot = int'(rnd() % 4);
      foreach (src[l])
        src[l] = (l + rot) % 4;
      apb(1'b1, `SRX_IDX_GEN_CTRL, 32'h0);
      apb(1'b1, `SRX_IDX_SUBCLASS, 32'(sc[c]));
      apb(1'b1, `SRX_IDX_OFFSET, 32'(ofs[c]));
      apb(1'b1, `SRX_IDX_RELEASE, 32'(rel[c]));
      apb(1'b1, `SRX_IDX_MAP_LOW, 32'(src[1] * 8 + src[0]));
      apb(1'b1, `SRX_IDX_MAP_HIGH, 32'(src[3] * 8 + src[2]));
      // Enable late in a multiframe so every lane starts on the same mark
      wait_tick();
      repeat (6) @(posedge clk);
      apb(1'b1, `SRX_IDX_GEN_CTRL, 32'h1);
      wait_tick();
      rx = -1;
      v = -1;
      for (int n = 1; n < 40; n++)
      begin
        @(posedge clk);
        if (rx_out === 1'b1 && rx < 0)
          rx = n;
        if (lout[0].valid === 1'b1 && v < 0)
        begin
          v = n;
          foreach (src[l])
          begin
            chk("lane source", lout[l].data[31:24], src[l]);
            chk("lane mark", lout[l].boundary, 32'h1);
          end
        end
      end
      e = (sc[c] == 1 && ofs[c] != 0) ? 2 * ofs[c] : ofs[c] + 1;
      chk("rx mark delay", rx, e);
      chk("release delay", v, e + rel[c]);
      if (ofs[c] == 0)
      begin
        apb(1'b0, `SRX_IDX_SKEW, 32'h0);
        chk("arrival skew", rd, 32'h4);
      end
    end
    conclude();
  end
endmodule // tb
